// file: common/sasvpd_pkg.sv
// Purpose: Shared constants and types for the port and logical unit VPD page responder
// Assumes: One response byte per accepted handshake, pages built from fixed constants
// Notes: Register addresses are word indexes on the plain register port
package sasvpd_pkg;

    // Supported page codes
    localparam logic [7:0] PAGE_LU_INFO = 8'h90;
    localparam logic [7:0] PAGE_PORT_INFO = 8'h91;

    // Page header fields
    localparam logic [2:0] QUALIFIER_VAL = 3'h0;
    localparam logic [4:0] DEV_TYPE_VAL = 5'h00;
    localparam logic [15:0] PAGE_LEN_VAL = 16'h0018;
    localparam int HDR_BYTES = 4;
    localparam int DESC_BYTES = 12;
    localparam logic [4:0] LAST_IDX = 5'h1B;

    // Per-port descriptor fields
    localparam logic [15:0] REL_PORT_PRIMARY = 16'h0001;
    localparam logic [3:0] PROTO_SAS_SSP = 4'h6;
    localparam logic [15:0] DESC_LEN_VAL = 16'h0004;
    localparam logic [3:0] TRANSPORT_RETRY_CTRL_VAL = 4'h0;
    localparam logic POWER_DISABLE_SUPPORTED_VAL = 1'b1;
    localparam logic [7:0] PHY_ID_PRIMARY = 8'h00;
    localparam logic PERSIST_CAPABLE_VAL = 1'b0;

    // Descriptor byte offsets
    localparam logic [3:0] OFF_REL_PORT_HI = 4'h0;
    localparam logic [3:0] OFF_REL_PORT_LO = 4'h1;
    localparam logic [3:0] OFF_PROTO = 4'h2;
    localparam logic [3:0] OFF_FLAGS = 4'h3;
    localparam logic [3:0] OFF_DESC_LEN_HI = 4'h6;
    localparam logic [3:0] OFF_DESC_LEN_LO = 4'h7;
    localparam logic [3:0] OFF_RETRY_PHY0 = 4'h8;
    localparam logic [3:0] OFF_PHY_ID = 4'h9;
    localparam logic [3:0] OFF_PHY_CAPS = 4'hA;

    // Register map, word indexes
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_SERVED = 4'h2;
    localparam logic [3:0] REG_REFUSED = 4'h3;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    typedef struct packed {
        logic evpd;
        logic [7:0] page_code;
    } sasvpd_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } sasvpd_rsp_t;

    typedef enum logic {
        SASVPD_IDLE,
        SASVPD_SEND
    } sasvpd_state_t;

endpackage : sasvpd_pkg

// file: rtl/sasvpd_table.sv
// Purpose: Byte lookup for the 90h and 91h pages, header plus two per-port descriptors
// Assumes: Page code already checked as one of the two supported pages
// Notes: Purely combinational; indexes past the page end return zero
`timescale 1ns/100ps

module sasvpd_table (
    input wire logic [7:0] i_page_code,
    input wire logic [4:0] i_index,
    output logic [7:0] o_byte
);

    logic port_page;
    logic [4:0] desc_idx;
    logic desc_port;
    logic [3:0] desc_off;
    logic [11:0][7:0] desc_sel;

    assign port_page = (i_page_code == sasvpd_pkg::PAGE_PORT_INFO);
    assign desc_idx = i_index - 5'(sasvpd_pkg::HDR_BYTES);
    assign desc_port = (desc_idx >= 5'(sasvpd_pkg::DESC_BYTES));
    assign desc_off = desc_port ? 4'(desc_idx - 5'(sasvpd_pkg::DESC_BYTES)) : desc_idx[3:0];

    genvar p;
    for (p = 0; p < 2; p++) begin : g_port
        localparam logic [15:0] REL = sasvpd_pkg::REL_PORT_PRIMARY + 16'(p);
        localparam logic [7:0] PHY = sasvpd_pkg::PHY_ID_PRIMARY + 8'(p);
        logic [11:0][7:0] d;
        always_comb begin
            d = '0;
            d[sasvpd_pkg::OFF_REL_PORT_HI] = REL[15:8];
            d[sasvpd_pkg::OFF_REL_PORT_LO] = REL[7:0];
            d[sasvpd_pkg::OFF_PROTO] = {4'h0, sasvpd_pkg::PROTO_SAS_SSP};
            d[sasvpd_pkg::OFF_DESC_LEN_LO] = sasvpd_pkg::DESC_LEN_VAL[7:0];
            d[sasvpd_pkg::OFF_DESC_LEN_HI] = sasvpd_pkg::DESC_LEN_VAL[15:8];
            if (port_page) begin
                d[sasvpd_pkg::OFF_FLAGS] = {7'h00, sasvpd_pkg::POWER_DISABLE_SUPPORTED_VAL};
                d[sasvpd_pkg::OFF_RETRY_PHY0] = 8'h00;
                d[sasvpd_pkg::OFF_PHY_ID] = PHY;
                d[sasvpd_pkg::OFF_PHY_CAPS] = {7'h00, sasvpd_pkg::PERSIST_CAPABLE_VAL};
            end else begin
                d[sasvpd_pkg::OFF_RETRY_PHY0] = {4'h0, sasvpd_pkg::TRANSPORT_RETRY_CTRL_VAL};
            end
        end
    end

    assign desc_sel = desc_port ? g_port[1].d : g_port[0].d;

    always_comb begin
        case (i_index)
            5'h00: o_byte = {sasvpd_pkg::QUALIFIER_VAL, sasvpd_pkg::DEV_TYPE_VAL};
            5'h01: o_byte = i_page_code;
            5'h02: o_byte = sasvpd_pkg::PAGE_LEN_VAL[15:8];
            5'h03: o_byte = sasvpd_pkg::PAGE_LEN_VAL[7:0];
            default: begin
                if (i_index <= sasvpd_pkg::LAST_IDX) begin
                    o_byte = desc_sel[desc_off];
                end else begin
                    o_byte = 8'h00;
                end
            end
        endcase
    end

endmodule : sasvpd_table

// file: rtl/sasvpd_responder.sv
// Purpose: Answers inquiry requests with VPD selection for pages 90h and 91h as a byte stream
// Assumes: Request and register port synchronous to i_clk; consumer may stall with i_out_ready
// Notes: Unsupported pages or a cleared selection bit are refused with a one-cycle pulse
//
// What this block does
// - Serve pages 90h and 91h when the request has VPD selection set.
// - Byte 0 of each page carries qualifier 0 and device type 0.
// - Byte 1 repeats the page code given in the request.
// - Bytes 2-3 hold page length 24 for both pages.
// - Page 90h carries two logical unit descriptors at bytes 4-15, 16-27.
// - Page 91h carries two port descriptors at bytes 4-15, 16-27.
// - Descriptor bytes 0-1 give relative port 1 for primary, 2 for secondary.
// - Descriptor byte 2 low nibble is SSP protocol code 6h, high nibble zero.
// - Logical unit descriptor byte 8 reports no transport retry control, value 0.
// - Port descriptor byte 3 bit 0 reports power disable supported.
// - Port descriptor bytes 8-11 carry one PHY information descriptor.
// - PHY descriptor byte 1 gives PHY 0 primary, 1 secondary.
// - PHY descriptor reports persistent connection capability as 0.
`timescale 1ns/100ps

module sasvpd_responder (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire sasvpd_pkg::sasvpd_req_t i_req,
    output logic o_req_ready,
    output logic o_req_refused,
    output logic o_out_valid,
    output sasvpd_pkg::sasvpd_rsp_t o_out,
    input wire logic i_out_ready,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);

    sasvpd_pkg::sasvpd_state_t state_r;
    sasvpd_pkg::sasvpd_state_t state_nxt;
    logic [7:0] page_r;
    logic [7:0] page_sel;
    logic [4:0] idx_r;
    logic [4:0] idx_nxt;
    logic [7:0] data_r;
    logic [7:0] tbl_byte;
    logic valid_r;
    logic refused_r;
    logic enable_r;
    logic [15:0] served_r;
    logic [15:0] refused_cnt_r;
    logic [31:0] rdata_r;
    logic page_ok;
    logic accept;
    logic refuse;
    logic fire;
    logic done;
    logic clear_cnt;

    assign page_ok = i_req.evpd && (i_req.page_code == sasvpd_pkg::PAGE_LU_INFO ||
                                    i_req.page_code == sasvpd_pkg::PAGE_PORT_INFO);
    assign o_req_ready = (state_r == sasvpd_pkg::SASVPD_IDLE);
    assign accept = o_req_ready && i_req_valid && enable_r && page_ok;
    assign refuse = o_req_ready && i_req_valid && !(enable_r && page_ok);
    assign fire = valid_r && i_out_ready;
    assign done = fire && (idx_r == sasvpd_pkg::LAST_IDX);
    assign clear_cnt = i_wr && (i_addr == sasvpd_pkg::REG_CTRL) && i_wdata[sasvpd_pkg::CTRL_CLEAR_BIT];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sasvpd_pkg::SASVPD_IDLE: begin
                if (accept) begin
                    state_nxt = sasvpd_pkg::SASVPD_SEND;
                end
            end
            sasvpd_pkg::SASVPD_SEND: begin
                if (done) begin
                    state_nxt = sasvpd_pkg::SASVPD_IDLE;
                end
            end
            default: state_nxt = sasvpd_pkg::SASVPD_IDLE;
        endcase
    end

    always_comb begin
        if (accept) begin
            idx_nxt = 5'h00;
        end else if (fire && !done) begin
            idx_nxt = idx_r + 5'h01;
        end else begin
            idx_nxt = idx_r;
        end
    end

    // Look ahead one byte so the data output is a flop and still keeps pace with the handshake
    assign page_sel = accept ? i_req.page_code : page_r;

    sasvpd_table u_table (
        .i_page_code(page_sel),
        .i_index(idx_nxt),
        .o_byte(tbl_byte)
    );

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= sasvpd_pkg::SASVPD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            idx_r <= 5'h00;
            page_r <= 8'h00;
        end else begin
            idx_r <= idx_nxt;
            if (accept) begin
                page_r <= i_req.page_code;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            valid_r <= 1'b0;
            data_r <= 8'h00;
        end else begin
            data_r <= tbl_byte;
            if (accept) begin
                valid_r <= 1'b1;
            end else if (done) begin
                valid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            refused_r <= 1'b0;
        end else begin
            refused_r <= refuse;
        end
    end

    assign o_out_valid = valid_r;
    // One driver for the whole struct keeps the output a single net for lint
    assign o_out = '{data: data_r, last: valid_r && (idx_r == sasvpd_pkg::LAST_IDX)};
    assign o_req_refused = refused_r;

    // Register port: control
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            enable_r <= sasvpd_pkg::CTRL_ENABLE_RST;
        end else if (i_wr && i_addr == sasvpd_pkg::REG_CTRL) begin
            enable_r <= i_wdata[sasvpd_pkg::CTRL_ENABLE_BIT];
        end
    end

    // A completion in the clearing cycle still counts, so the clear never hides an event
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            served_r <= sasvpd_pkg::COUNT_RST;
        end else if (done) begin
            served_r <= (clear_cnt ? sasvpd_pkg::COUNT_RST : served_r) + 16'h0001;
        end else if (clear_cnt) begin
            served_r <= sasvpd_pkg::COUNT_RST;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            refused_cnt_r <= sasvpd_pkg::COUNT_RST;
        end else if (refuse) begin
            refused_cnt_r <= (clear_cnt ? sasvpd_pkg::COUNT_RST : refused_cnt_r) + 16'h0001;
        end else if (clear_cnt) begin
            refused_cnt_r <= sasvpd_pkg::COUNT_RST;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                sasvpd_pkg::REG_CTRL: rdata_r <= {31'h0000_0000, enable_r};
                sasvpd_pkg::REG_STATUS: rdata_r <= {11'h000, idx_r, page_r, 7'h00, valid_r};
                sasvpd_pkg::REG_SERVED: rdata_r <= {16'h0000, served_r};
                sasvpd_pkg::REG_REFUSED: rdata_r <= {16'h0000, refused_cnt_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_r;

    a_page_accept: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_req_ready && i_req_valid && enable_r && i_req.evpd &&
         i_req.page_code inside {8'h90, 8'h91})
        |=> o_out_valid && !o_req_refused && (page_r == $past(i_req.page_code))
    ) else $error("supported page request not served");

    a_no_vpd_refused: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_req_ready && i_req_valid && !i_req.evpd) |=> o_req_refused && !o_out_valid
    ) else $error("request without VPD selection not refused");

    a_header_byte0: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r == 5'h00) |-> (o_out.data == 8'h00)
    ) else $error("qualifier or device type not zero");

    a_header_page: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r == 5'h01) |-> (o_out.data == page_r)
    ) else $error("page code not echoed");

    a_header_length: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r == 5'h02 && i_out_ready) |=> (o_out.data == 8'h18) &&
        $past(o_out.data) == 8'h00
    ) else $error("page length not 24");

    a_lu_frame: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && page_r == 8'h90 && idx_r inside {5'h04, 5'h10}) |-> o_out.data == 8'h00
        ##0 (idx_r != 5'h1B) ##0 !o_out.last
    ) else $error("logical unit descriptor misplaced");

    a_stream_end: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && o_out.last && i_out_ready) |-> (idx_r == 5'h1B) ##1
        (!o_out_valid && o_req_ready)
    ) else $error("page does not end after byte 27");

    a_rel_port: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r inside {5'h05, 5'h11}) |->
        (o_out.data == ((idx_r == 5'h05) ? 8'h01 : 8'h02))
    ) else $error("relative port number wrong");

    a_proto_code: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r inside {5'h06, 5'h12}) |-> (o_out.data == 8'h06)
    ) else $error("protocol code not SSP");

    a_retry_ctrl: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && page_r == 8'h90 && idx_r inside {5'h0C, 5'h18}) |-> (o_out.data == 8'h00)
    ) else $error("transport retry support not zero");

    a_power_disable: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r inside {5'h07, 5'h13}) |->
        (o_out.data == ((page_r == 8'h91) ? 8'h01 : 8'h00))
    ) else $error("power disable flag wrong");

    a_phy_desc: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && page_r == 8'h91 && idx_r inside {5'h0C, 5'h0F, 5'h18, 5'h1B}) |->
        (o_out.data == 8'h00)
    ) else $error("PHY descriptor reserved byte nonzero");

    a_phy_number: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && page_r == 8'h91 && idx_r inside {5'h0D, 5'h19}) |->
        (o_out.data == ((idx_r == 5'h0D) ? 8'h00 : 8'h01))
    ) else $error("PHY number wrong");

    a_persist_cap: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && page_r == 8'h91 && idx_r inside {5'h0E, 5'h1A}) |-> (o_out.data == 8'h00)
    ) else $error("persistent capability not zero");

    a_desc_length: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && idx_r inside {5'h08, 5'h09, 5'h0A, 5'h14, 5'h15, 5'h16}) |->
        ((o_out.data == 8'h00) and
         ((idx_r inside {5'h0A, 5'h16} && i_out_ready) |=> (o_out.data == 8'h04)))
    ) else $error("descriptor length or reserved bytes wrong");

    a_stall_hold: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_out_valid && !i_out_ready) |=> o_out_valid && $stable(o_out.data) && $stable(idx_r)
    ) else $error("byte changed while stalled");

endmodule : sasvpd_responder

// file: testbench/sasvpd_initiator_model.sv
// Purpose: Initiator side model that takes page bytes and keeps what it got
// Assumes: One byte per valid and ready edge; i_slow makes it stall every other cycle
// Notes: Counts past 28 so an overlong page shows up in o_cnt
`timescale 1ns/100ps

module sasvpd_initiator_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire sasvpd_pkg::sasvpd_rsp_t i_out,
    output logic o_ready,
    output logic [7:0] o_bytes [0:27],
    output logic [5:0] o_cnt,
    output logic [5:0] o_last_idx
);
    // Stalling on alternate cycles checks that data holds while not taken
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= i_slow ? ~o_ready : 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset || i_clear) begin
            o_cnt <= 6'h00;
            o_last_idx <= 6'h3F;
        end else if (i_valid && o_ready) begin
            if (o_cnt < 6'h1C) begin
                o_bytes[o_cnt[4:0]] <= i_out.data;
            end
            if (i_out.last) begin
                o_last_idx <= o_cnt;
            end
            o_cnt <= o_cnt + 6'h01;
        end
    end
endmodule : sasvpd_initiator_model

// file: testbench/sas_port_vpd_page_responder_bench.sv
// Purpose: Self-checking bench for the 90h and 91h page responder
// Assumes: Expected bytes are worked out here from the page layout
// Notes: Each scenario task drives the block and judges the result itself
`timescale 1ns/100ps

`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin \
    miscompares++; $display("BAD %0t %s", $time, msg); end end

module sas_port_vpd_page_responder_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    sasvpd_pkg::sasvpd_req_t req = '0;
    logic req_ready, refused, out_valid, out_ready;
    sasvpd_pkg::sasvpd_rsp_t out;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic clr = 1'b0;
    logic slow = 1'b0;
    logic [7:0] got [0:27];
    logic [5:0] cnt, last_idx;
    int compares = 0;
    int miscompares = 0;

    always #12.5 clk = ~clk;

    sasvpd_responder i_dut (.i_clk(clk), .i_reset(rst), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(req_ready), .o_req_refused(refused), .o_out_valid(out_valid),
        .o_out(out), .i_out_ready(out_ready), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata));

    sasvpd_initiator_model i_host (.i_clk(clk), .i_reset(rst), .i_clear(clr), .i_slow(slow),
        .i_valid(out_valid), .i_out(out), .o_ready(out_ready), .o_bytes(got), .o_cnt(cnt),
        .o_last_idx(last_idx));

    function automatic logic [7:0] expb(input logic [7:0] pg, input int i);
        int d;
        int port;
        d = (i - 4) % 12;
        port = (i - 4) / 12;
        if (i == 1) return pg;
        if (i == 3) return 8'h18;
        if (i < 4) return 8'h00;
        if (d == 1) return 8'(port + 1);
        if (d == 2) return 8'h06;
        if (d == 3) return (pg == 8'h91) ? 8'h01 : 8'h00;
        if (d == 7) return 8'h04;
        if (d == 9) return (pg == 8'h91) ? 8'(port) : 8'h00;
        return 8'h00;
    endfunction : expb

    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic send(input logic ev, input logic [7:0] pg);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        req_valid <= 1'b1;
        req <= '{evpd: ev, page_code: pg};
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : send

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata & m, exp, "register read")
    endtask : rd_reg

    // Whole page, byte by byte, with the final byte the latest one to carry last
    task automatic page(input logic [7:0] pg, input logic stall);
        int n;
        slow <= stall;
        send(1'b1, pg);
        n = 0;
        while (cnt < 6'h1C && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        `CHK(out_valid, 1'b0, "valid after page")
        `CHK(req_ready, 1'b1, "ready after page")
        `CHK(cnt, 6'h1C, "page byte count")
        `CHK(last_idx, 6'h1B, "last flag position")
        for (int i = 0; i < 28; i++) begin
            `CHK(got[i], expb(pg, i), "page byte")
        end
    endtask : page

    // Refused request gives a one-cycle pulse and no stream
    task automatic refuse(input logic ev, input logic [7:0] pg);
        send(ev, pg);
        #1;
        `CHK(refused, 1'b1, "refuse pulse")
        `CHK(out_valid, 1'b0, "no stream on refuse")
        @(posedge clk);
        #1;
        `CHK(refused, 1'b0, "refuse pulse length")
        `CHK(out_valid, 1'b0, "still no stream")
    endtask : refuse

    initial begin
        #(25 * 20000);
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(sasvpd_pkg::REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
        rd_reg(sasvpd_pkg::REG_SERVED, 32'h0000_0000, 32'hFFFF_FFFF);
        page(8'h90, 1'b0);
        page(8'h91, 1'b1);
        rd_reg(sasvpd_pkg::REG_SERVED, 32'h0000_0002, 32'hFFFF_FFFF);
        rd_reg(sasvpd_pkg::REG_STATUS, 32'h0000_9100, 32'h0000_FF01);
        refuse(1'b0, 8'h90);
        refuse(1'b1, 8'h80);
        refuse(1'b1, 8'h92);
        rd_reg(sasvpd_pkg::REG_REFUSED, 32'h0000_0003, 32'hFFFF_FFFF);
        rd_reg(4'hF, 32'h0000_0000, 32'hFFFF_FFFF);
        wr_reg(sasvpd_pkg::REG_CTRL, 32'h0000_0000);
        refuse(1'b1, 8'h90);
        rd_reg(sasvpd_pkg::REG_REFUSED, 32'h0000_0004, 32'hFFFF_FFFF);
        wr_reg(sasvpd_pkg::REG_CTRL, 32'h0000_0003);
        rd_reg(sasvpd_pkg::REG_SERVED, 32'h0000_0000, 32'hFFFF_FFFF);
        rd_reg(sasvpd_pkg::REG_REFUSED, 32'h0000_0000, 32'hFFFF_FFFF);
        rd_reg(sasvpd_pkg::REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
        page(8'h91, 1'b0);
        page(8'h90, 1'b1);
        rd_reg(sasvpd_pkg::REG_SERVED, 32'h0000_0002, 32'hFFFF_FFFF);
        summarize();
    end
endmodule : sas_port_vpd_page_responder_bench
